// [rtl/bkpreg_pkg.sv]
// backup register bank: shared constants, register map and types
// assumes a 32-bit AXI4-Lite slave with one aligned word per register
`default_nettype none

package bkpreg_pkg;

  // =========================================================
  // geometry
  localparam int NUM_WORDS = 16;
  localparam int WORD_W    = 16;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 32;
  localparam int CAL_W     = 7;
  localparam int WIN_W     = 20;
  localparam int DIV_W     = 6;
  localparam int SYNC_N    = 4;

  // =========================================================
  // register map (byte addresses)
  localparam logic [ADDR_W-1:0] DATA_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] DATA_LAST = 8'h3C;
  localparam logic [ADDR_W-1:0] CAL_ADDR  = 8'h40;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h44;

  // status register bit positions
  localparam int STAT_OPEN = 0;
  localparam int STAT_PIN  = 1;
  localparam int STAT_DRV  = 2;

  // reset values
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

  // synchroniser lane positions
  localparam int LN_RTC   = 0;
  localparam int LN_ALARM = 1;
  localparam int LN_SEC   = 2;
  localparam int LN_PDN   = 3;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // =========================================================
  // types
  // field order gives bits 9, 8, 7 and 6:0 of the calibration word
  typedef struct packed {
    logic             src_sel;
    logic             pulse_en;
    logic             cal_clock_output_enable;
    logic [CAL_W-1:0] cal;
  } bkpreg_cal_t;

  localparam bkpreg_cal_t CAL_RST = '{src_sel: 1'b0, pulse_en: 1'b0,
                                      cal_clock_output_enable: 1'b0, cal: 7'h00};

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP    = 2'b10
  } bkpreg_wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } bkpreg_rd_state_t;

  // =========================================================
  // helpers
  function automatic logic [WORD_W-1:0] merge_lanes(
    input logic [WORD_W-1:0] old_val,
    input logic [DATA_W-1:0] wdata,
    input logic [3:0]        wstrb
  );
    logic [WORD_W-1:0] res;
    res = old_val;
    if (wstrb[0])
    begin
      res[7:0] = wdata[7:0];
    end
    if (wstrb[1])
    begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  function automatic logic is_data_addr(input logic [ADDR_W-1:0] a);
    return (a >= DATA_BASE) && (a <= DATA_LAST) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [3:0] word_index(input logic [ADDR_W-1:0] a);
    return a[5:2];
  endfunction

endpackage

`default_nettype wire

// [rtl/bkpreg_sync.sv]
// two-flop synchroniser for a group of level inputs
// assumes inputs are asynchronous to clk; only dst_o may be read
`default_nettype none

module bkpreg_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,     // destination clock
  input  wire logic         rst_n,   // synchronous reset, active low
  input  wire logic [W-1:0] src_i,   // asynchronous inputs
  output logic      [W-1:0] dst_o    // synchronised outputs
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // =========================================================
  // two stages, nothing taps the first
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= src_i;
      sync_q <= meta_q;
    end
  end

  assign dst_o = sync_q;

endmodule

`default_nettype wire

// [rtl/bkpreg_top.sv]
// backup register bank with rtc calibration and rtc output pin control
// assumes aclk drives the bank, rtc signals arrive asynchronously,
// bkp_resetn is the backup-domain reset and aresetn the system reset
//
// Functional notes
// - sixteen 16-bit data words give 32 bytes of backup storage.
// - data words survive standby wake-up, system reset and power reset.
// - only the backup-domain reset clears data words to zero.
// - register access is refused while any of the three enables is low (status reads excepted), guarding against stray writes.
// - calibration clock output drives rtc clock divided by 64 on the pin.
// - pulse output enable drives alarm or seconds pulse unless calibration clock output is set; clear disables it.
// - source select 0 picks alarm pulse, 1 picks seconds pulse.
// - each pulse on the pin lasts one rtc clock period.
// - source select and pulse enable clear only on backup-domain reset.
// - calibration clock output bit clears when main supply powers off.
// - drop calibration-field count of pulses in every 2^20 rtc pulses.
// - slowing spans zero to about 121 ppm in 2^-20 steps.
`default_nettype none

module bkpreg_top
  import bkpreg_pkg::*;
(
  input  wire logic              aclk,                   // bus clock
  input  wire logic              aresetn,                // system reset
  input  wire logic              bkp_resetn,             // backup-domain reset
  input  wire logic              main_supply_off,        // main supply down
  input  wire logic              power_if_clock_enable,  // power if clock on
  input  wire logic              backup_if_clock_enable, // backup if clock on
  input  wire logic              backup_access_enable,   // access enable bit
  input  wire logic              rtc_clk_in,             // rtc clock
  input  wire logic              alarm_pulse_in,         // rtc alarm pulse
  input  wire logic              second_pulse_in,        // rtc seconds pulse
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,           // write address
  input  wire logic              s_axi_awvalid,          // write addr valid
  output logic                   s_axi_awready,          // write addr ready
  input  wire logic [DATA_W-1:0] s_axi_wdata,            // write data
  input  wire logic [3:0]        s_axi_wstrb,            // byte enables
  input  wire logic              s_axi_wvalid,           // write data valid
  output logic                   s_axi_wready,           // write data ready
  output logic [1:0]             s_axi_bresp,            // write answer
  output logic                   s_axi_bvalid,           // write answer valid
  input  wire logic              s_axi_bready,           // write answer ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,           // read address
  input  wire logic              s_axi_arvalid,          // read addr valid
  output logic                   s_axi_arready,          // read addr ready
  output logic [DATA_W-1:0]      s_axi_rdata,            // read data
  output logic [1:0]             s_axi_rresp,            // read answer
  output logic                   s_axi_rvalid,           // read data valid
  input  wire logic              s_axi_rready,           // read data ready
  output logic                   rtc_output_pin,         // rtc output level
  output logic                   rtc_output_pin_oe_n,    // low while driven
  output logic                   cal_rtc_tick            // calibrated rtc tick
);

  // =========================================================
  // input synchronisers and edge detection
  logic [SYNC_N-1:0] sync_s;
  logic [2:0]        prev_q;
  logic [2:0]        prev_d;
  logic              rtc_rise;
  logic              alarm_rise;
  logic              sec_rise;
  logic              pdn_s;

  bkpreg_sync #(.W(SYNC_N)) bkpreg_sync_i (
    .clk   (aclk),
    .rst_n (bkp_resetn),
    .src_i ({main_supply_off, second_pulse_in, alarm_pulse_in, rtc_clk_in}),
    .dst_o (sync_s)
  );

  always_comb
  begin
    prev_d     = sync_s[LN_SEC:LN_RTC];
    rtc_rise   = sync_s[LN_RTC] & ~prev_q[LN_RTC];
    alarm_rise = sync_s[LN_ALARM] & ~prev_q[LN_ALARM];
    sec_rise   = sync_s[LN_SEC] & ~prev_q[LN_SEC];
    pdn_s      = sync_s[LN_PDN];
  end

  always_ff @(posedge aclk)
  begin
    if (!bkp_resetn)
      prev_q <= '0;
    else
      prev_q <= prev_d;
  end

  // =========================================================
  // access gate: the three enables come from neighbouring control logic
  logic access_open;
  assign access_open = power_if_clock_enable & backup_if_clock_enable
                       & backup_access_enable;

  // =========================================================
  // write channel
  bkpreg_wr_state_t  wr_st_q, wr_st_d;
  logic              aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic [3:0]        wstrb_q, wstrb_d;
  logic [1:0]        bresp_q, bresp_d;
  logic              commit;

  always_comb
  begin
    wr_st_d       = wr_st_q;
    aw_have_d     = aw_have_q;
    w_have_d      = w_have_q;
    awaddr_d      = awaddr_q;
    wdata_d       = wdata_q;
    wstrb_d       = wstrb_q;
    bresp_d       = bresp_q;
    commit        = 1'b0;
    s_axi_awready = (wr_st_q == WR_COLLECT) && !aw_have_q;
    s_axi_wready  = (wr_st_q == WR_COLLECT) && !w_have_q;
    s_axi_bvalid  = (wr_st_q == WR_RESP);
    case (wr_st_q)
      WR_COLLECT:
      begin
        if (s_axi_awvalid && s_axi_awready)
        begin
          aw_have_d = 1'b1;
          awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
          w_have_d = 1'b1;
          wdata_d  = s_axi_wdata;
          wstrb_d  = s_axi_wstrb;
        end
        if (aw_have_d && w_have_d)
        begin
          commit    = 1'b1;
          aw_have_d = 1'b0;
          w_have_d  = 1'b0;
          wr_st_d   = WR_RESP;
          if (!is_data_addr(awaddr_d) && awaddr_d != CAL_ADDR
              && awaddr_d != STAT_ADDR)
            bresp_d = RESP_DECERR;
          else if (!access_open)
            bresp_d = RESP_SLVERR;
          else
            bresp_d = RESP_OKAY;
        end
      end
      WR_RESP:
      begin
        if (s_axi_bready)
          wr_st_d = WR_COLLECT;
      end
      default:
        wr_st_d = WR_COLLECT;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_st_q   <= WR_COLLECT;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bresp_q   <= RESP_OKAY;
    end
    else
    begin
      wr_st_q   <= wr_st_d;
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bresp_q   <= bresp_d;
    end
  end

  assign s_axi_bresp = bresp_q;

  // =========================================================
  // backup-domain storage: of the resets only bkp_resetn clears it, so system and
  // power resets (aresetn) leave contents alone
  logic [NUM_WORDS-1:0][WORD_W-1:0] data_q, data_d;
  bkpreg_cal_t                      cal_q, cal_d;
  logic                             wr_ok;

  always_comb
  begin
    data_d = data_q;
    cal_d  = cal_q;
    wr_ok  = commit && access_open;
    if (wr_ok && is_data_addr(awaddr_d))
      data_d[word_index(awaddr_d)] = merge_lanes(data_q[word_index(awaddr_d)],
                                                 wdata_d, wstrb_d);
    if (wr_ok && awaddr_d == CAL_ADDR)
      cal_d = bkpreg_cal_t'(merge_lanes(WORD_W'(cal_q), wdata_d, wstrb_d));
    // supply loss outranks a write landing in the same cycle
    if (pdn_s)
      cal_d.cal_clock_output_enable = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!bkp_resetn)
    begin
      data_q <= {NUM_WORDS{WORD_RST}};
      cal_q  <= CAL_RST;
    end
    else
    begin
      data_q <= data_d;
      cal_q  <= cal_d;
    end
  end

  // =========================================================
  // read channel
  bkpreg_rd_state_t  rd_st_q, rd_st_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [1:0]        rresp_q, rresp_d;

  always_comb
  begin
    rd_st_d       = rd_st_q;
    rdata_d       = rdata_q;
    rresp_d       = rresp_q;
    s_axi_arready = (rd_st_q == RD_IDLE);
    s_axi_rvalid  = (rd_st_q == RD_DATA);
    case (rd_st_q)
      RD_IDLE:
      begin
        if (s_axi_arvalid)
        begin
          rd_st_d = RD_DATA;
          rdata_d = '0;
          rresp_d = RESP_OKAY;
          if (s_axi_araddr == STAT_ADDR)
          begin
            // status stays readable so software can see why it is locked out
            rdata_d[STAT_OPEN] = access_open;
            rdata_d[STAT_PIN]  = rtc_output_pin;
            rdata_d[STAT_DRV]  = !rtc_output_pin_oe_n;
          end
          else if (!is_data_addr(s_axi_araddr) && s_axi_araddr != CAL_ADDR)
            rresp_d = RESP_DECERR;
          else if (!access_open)
            rresp_d = RESP_SLVERR;
          else if (s_axi_araddr == CAL_ADDR)
            rdata_d[WORD_W-1:0] = WORD_W'(cal_q);
          else
            rdata_d[WORD_W-1:0] = data_q[word_index(s_axi_araddr)];
        end
      end
      RD_DATA:
      begin
        if (s_axi_rready)
          rd_st_d = RD_IDLE;
      end
      default:
        rd_st_d = RD_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_st_q <= RD_IDLE;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end
    else
    begin
      rd_st_q <= rd_st_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // =========================================================
  // rtc calibration, divider, pulse stretcher and pin mux
  logic [WIN_W-1:0] win_q, win_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic             tick_q, tick_d, pulse_q, pulse_d;
  logic             pin_q, pin_d, oe_n_q, oe_n_d;
  logic             pulse_ev;

  always_comb
  begin
    win_d    = win_q;
    div_d    = div_q;
    tick_d   = 1'b0;
    pulse_d  = pulse_q;
    pulse_ev = cal_q.src_sel ? sec_rise : alarm_rise;
    if (rtc_rise)
    begin
      // the window wraps by itself; the first cal pulses of it are dropped
      win_d  = win_q + 20'h00001;
      tick_d = (win_q >= WIN_W'(cal_q.cal));
      div_d  = div_q + 6'h01;
      pulse_d = 1'b0;
    end
    if (cal_q.pulse_en && pulse_ev)
      pulse_d = 1'b1;
    if (cal_q.cal_clock_output_enable)
      pin_d = div_q[DIV_W-1];
    else
      pin_d = cal_q.pulse_en & pulse_q;
    oe_n_d = !(cal_q.cal_clock_output_enable || cal_q.pulse_en);
  end

  always_ff @(posedge aclk)
  begin
    if (!bkp_resetn)
    begin
      win_q   <= '0;
      div_q   <= '0;
      tick_q  <= 1'b0;
      pulse_q <= 1'b0;
      pin_q   <= 1'b0;
      oe_n_q  <= 1'b1;
    end
    else
    begin
      win_q   <= win_d;
      div_q   <= div_d;
      tick_q  <= tick_d;
      pulse_q <= pulse_d;
      pin_q   <= pin_d;
      oe_n_q  <= oe_n_d;
    end
  end

  assign rtc_output_pin      = pin_q;
  assign rtc_output_pin_oe_n = oe_n_q;
  assign cal_rtc_tick        = tick_q;

  // =========================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_pulse_event;
    cal_q.pulse_en && pulse_ev;
  endsequence

  sequence s_pulse_end;
    rtc_rise && pulse_q && !(cal_q.pulse_en && pulse_ev);
  endsequence

  a_locked_write: assert property (bkp_resetn && commit && !access_open
    |=> $stable(data_q) && $stable(cal_q))
    else $error("write changed backup state while locked");
  a_data_retained: assert property (@(posedge aclk) disable iff (!bkp_resetn)
    !wr_ok |=> $stable(data_q))
    else $error("backup data changed without a write");
  a_bkp_clear: assert property (!bkp_resetn
    |=> data_q == '0 && cal_q == CAL_RST)
    else $error("backup reset did not clear registers");
  a_div_toggle: assert property (bkp_resetn && cal_q.cal_clock_output_enable && rtc_rise
    && div_q == 6'h1F ##1 cal_q.cal_clock_output_enable |=> rtc_output_pin)
    else $error("divided clock did not rise after 32 rtc edges");
  a_pulse_off: assert property (!cal_q.cal_clock_output_enable && !cal_q.pulse_en
    |=> rtc_output_pin_oe_n && !rtc_output_pin)
    else $error("pin driven with outputs disabled");
  a_pulse_source: assert property (bkp_resetn && !cal_q.src_sel
    && cal_q.pulse_en && alarm_rise |=> pulse_q)
    else $error("alarm pulse not captured");
  a_pulse_len: assert property (bkp_resetn and s_pulse_end
    |=> !pulse_q)
    else $error("pulse outlived one rtc period");
  a_pulse_start: assert property (bkp_resetn and s_pulse_event
    |=> pulse_q)
    else $error("pulse not started on event");
  a_sel_retained: assert property (@(posedge aclk) disable iff (!bkp_resetn)
    !(wr_ok && awaddr_d == CAL_ADDR)
    |=> $stable(cal_q.src_sel) && $stable(cal_q.pulse_en))
    else $error("pulse control changed without a write");
  a_cco_pdn: assert property (bkp_resetn && pdn_s |=> !cal_q.cal_clock_output_enable)
    else $error("cco survived supply loss");
  a_cal_skip: assert property (bkp_resetn && rtc_rise
    |=> cal_rtc_tick == ($past(win_q) >= WIN_W'($past(cal_q.cal))))
    else $error("calibration skip wrong");
  a_pin_prio: assert property (bkp_resetn && cal_q.cal_clock_output_enable && cal_q.pulse_en
    && !div_q[DIV_W-1] |=> !rtc_output_pin)
    else $error("pulse overrode calibration clock");

endmodule

`default_nettype wire

// [sim/bkpreg_top_tb.sv]
// bench for the backup register bank: bus access, gating, rtc pin, calibration
// assumes bkpreg_pkg is compiled first; this module drives every port itself
`default_nettype none

module bkpreg_top_tb
  import bkpreg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ===========================================================
  // signals
  localparam int CYC_LIMIT = 20000;
  logic              aclk, aresetn, bkp_resetn, main_supply_off;
  logic              power_if_clock_enable, backup_if_clock_enable, backup_access_enable;
  logic              rtc_clk_in, alarm_pulse_in, second_pulse_in;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  logic              rtc_output_pin, rtc_output_pin_oe_n, cal_rtc_tick, pin_prev;
  int                n_errors, tests_run, cyc, hi_cnt, tog_cnt, tick_cnt;

  bkpreg_top bkpreg_top_i (
    .aclk(aclk), .aresetn(aresetn), .bkp_resetn(bkp_resetn),
    .main_supply_off(main_supply_off),
    .power_if_clock_enable(power_if_clock_enable),
    .backup_if_clock_enable(backup_if_clock_enable),
    .backup_access_enable(backup_access_enable),
    .rtc_clk_in(rtc_clk_in), .alarm_pulse_in(alarm_pulse_in),
    .second_pulse_in(second_pulse_in),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .rtc_output_pin(rtc_output_pin),
    .rtc_output_pin_oe_n(rtc_output_pin_oe_n), .cal_rtc_tick(cal_rtc_tick)
  );

  always #50 aclk = ~aclk;

  // ===========================================================
  // monitors and watchdog; values are those present at the edge
  always @(posedge aclk)
  begin
    cyc++;
    if (rtc_output_pin === 1'b1)
      hi_cnt++;
    if (rtc_output_pin !== pin_prev)
      tog_cnt++;
    if (cal_rtc_tick === 1'b1)
      tick_cnt++;
    pin_prev = rtc_output_pin;
    if (cyc == CYC_LIMIT)
    begin
      n_errors++;
      $display("timeout at %0t", $time);
      test_done;
    end
  end

  // ===========================================================
  // shared tasks
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [1:0] r, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        r = s_axi_rresp;
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  // rtc period is ten bus cycles; events ride on the first rising edge only
  task automatic rtc_run(input int n, input logic al, input logic se);
    for (int k = 0; k < n; k++)
    begin
      @(posedge aclk);
      rtc_clk_in <= 1'b1;
      alarm_pulse_in <= al && (k == 0);
      second_pulse_in <= se && (k == 0);
      repeat (5) @(posedge aclk);
      rtc_clk_in <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    repeat (5) @(posedge aclk);
  endtask

  task automatic bkp_reset;
    @(posedge aclk);
    bkp_resetn <= 1'b0;
    repeat (2) @(posedge aclk);
    bkp_resetn <= 1'b1;
  endtask

  // ===========================================================
  // scenarios
  task automatic t_access;
    logic [1:0]  r;
    logic [31:0] d;
    wr(DATA_BASE, 32'h0000_1234, 4'hF, r);
    check({r, 32'h0}, {RESP_SLVERR, 32'h0});
    rd(DATA_BASE, r, d);
    check({r, d}, {RESP_SLVERR, 32'h0});
    for (int k = 0; k < 3; k++)
    begin
      power_if_clock_enable <= (k != 0);
      backup_if_clock_enable <= (k != 1);
      backup_access_enable <= (k != 2);
      wr(CAL_ADDR, 32'h0000_0080, 4'hF, r);
      check({r, 32'h0}, {RESP_SLVERR, 32'h0});
    end
    power_if_clock_enable <= 1'b1;
    backup_if_clock_enable <= 1'b1;
    backup_access_enable <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(STAT_ADDR, r, d);
    check({r, 31'h0, d[STAT_OPEN]}, {RESP_OKAY, 32'h1});
    rd(DATA_BASE, r, d);
    check({r, d}, {RESP_OKAY, 32'h0});
    rd(CAL_ADDR, r, d);
    check({r, d}, {RESP_OKAY, 32'h0});
    $display("test access done");
  endtask

  task automatic t_data;
    logic [1:0]  r;
    logic [31:0] d;
    for (int i = 0; i < 16; i++)
    begin
      wr(DATA_BASE + 8'(4 * i), {16'hFFFF, 16'h1000 + 16'(i) * 16'h0111}, 4'hF, r);
      check({r, 32'h0}, {RESP_OKAY, 32'h0});
    end
    for (int i = 0; i < 16; i++)
    begin
      rd(DATA_BASE + 8'(4 * i), r, d);
      check({r, d}, {RESP_OKAY, 16'h0, 16'h1000 + 16'(i) * 16'h0111});
    end
    wr(DATA_LAST, 32'h0000_BEEF, 4'h1, r);
    rd(DATA_LAST, r, d);
    check({r, d}, {RESP_OKAY, 32'h0000_1FEF});
    wr(8'h80, 32'h0000_5555, 4'hF, r);
    check({r, 32'h0}, {RESP_DECERR, 32'h0});
    rd(8'h48, r, d);
    check({r, d}, {RESP_DECERR, 32'h0});
    $display("test data done");
  endtask

  task automatic t_keep;
    logic [1:0]  r;
    logic [31:0] d;
    wr(DATA_BASE + 8'h08, 32'h0000_A5C3, 4'hF, r);
    wr(CAL_ADDR, 32'h0000_0305, 4'hF, r);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(DATA_BASE + 8'h08, r, d);
    check({r, d}, {RESP_OKAY, 32'h0000_A5C3});
    rd(CAL_ADDR, r, d);
    check({r, d}, {RESP_OKAY, 32'h0000_0305});
    bkp_reset;
    rd(DATA_BASE + 8'h08, r, d);
    check({r, d}, {RESP_OKAY, 32'h0});
    rd(CAL_ADDR, r, d);
    check({r, d}, {RESP_OKAY, 32'h0});
    $display("test retention done");
  endtask

  task automatic t_pulse;
    logic [1:0] r;
    for (int s = 0; s < 2; s++)
    begin
      wr(CAL_ADDR, (s == 1) ? 32'h0000_0300 : 32'h0000_0100, 4'hF, r);
      hi_cnt = 0;
      rtc_run(3, s == 0, s == 1);
      check(34'(hi_cnt >= 9 && hi_cnt <= 11), 34'h1);
      hi_cnt = 0;
      rtc_run(3, s == 1, s == 0);
      check(34'(hi_cnt), 34'h0);
      // the pin's other function is never enabled while pulses are on
      check({33'h0, rtc_output_pin_oe_n}, 34'h0);
    end
    wr(CAL_ADDR, 32'h0000_0000, 4'hF, r);
    hi_cnt = 0;
    rtc_run(2, 1'b1, 1'b1);
    check(34'(hi_cnt), 34'h0);
    check({33'h0, rtc_output_pin_oe_n}, 34'h1);
    $display("test pulse done");
  endtask

  task automatic t_cco;
    logic [1:0]  r;
    logic [31:0] d;
    wr(CAL_ADDR, 32'h0000_0180, 4'hF, r);
    repeat (5) @(posedge aclk);
    tog_cnt = 0;
    rtc_run(128, 1'b1, 1'b0);
    check(34'(tog_cnt), 34'h4);
    check({33'h0, rtc_output_pin_oe_n}, 34'h0);
    rd(STAT_ADDR, r, d);
    check({r, 31'h0, d[STAT_DRV]}, {RESP_OKAY, 32'h1});
    main_supply_off <= 1'b1;
    repeat (5) @(posedge aclk);
    main_supply_off <= 1'b0;
    repeat (5) @(posedge aclk);
    rd(CAL_ADDR, r, d);
    check({r, d}, {RESP_OKAY, 32'h0000_0100});
    $display("test divided clock done");
  endtask

  // window restarts at backup reset, so the skipped edges come first
  task automatic t_cal(input logic [6:0] c, input int n, input int exp);
    logic [1:0] r;
    bkp_reset;
    wr(CAL_ADDR, {25'h0, c}, 4'hF, r);
    tick_cnt = 0;
    rtc_run(n, 1'b0, 1'b0);
    check(34'(tick_cnt), 34'(exp));
    $display("test calibration %0d done", c);
  endtask

  // ===========================================================
  // main sequence
  initial
  begin
    {aclk, aresetn, bkp_resetn, main_supply_off} = 4'h0;
    {power_if_clock_enable, backup_if_clock_enable, backup_access_enable} = 3'h0;
    {rtc_clk_in, alarm_pulse_in, second_pulse_in, pin_prev} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    {n_errors, tests_run, cyc, hi_cnt, tog_cnt, tick_cnt} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    bkp_resetn <= 1'b1;
    t_access;
    t_data;
    t_keep;
    t_pulse;
    t_cco;
    t_cal(7'h00, 20, 20);
    t_cal(7'h05, 20, 15);
    t_cal(7'h7F, 130, 3);
    test_done;
  end

endmodule

`default_nettype wire
